//--- core/apm_adc_ctrl.sv
// Purpose: start, done flag, channel select and power-mode handling of the 8-bit converter
// Assumes: clk is the cpu clock; rc oscillator and analog code arrive as pins
// Notes: power_down high models the stopped cpu clock domain
`timescale 1ns/1ps
`include "apm_defines.svh"

module apm_adc_ctrl #(
  parameter int CLKS_PER_MC = `APM_CLKS_PER_MC,
  parameter int CPU_MC = `APM_CPU_MC,
  parameter int SYNC_MC = `APM_SYNC_MC,
  parameter int RC_TICKS = `APM_RC_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire apm_pkg::apm_sw_type sw,
  input wire logic converter_rc_clock_select,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic adc_int_en,
  input wire logic rc_osc_pin,
  input wire logic [`APM_RES_W-1:0] analog_code,
  output logic conversion_start_flag,
  output logic conversion_done_flag,
  output logic [`APM_RES_W-1:0] conversion_result_reg,
  output logic result_valid,
  output logic [`APM_CHAN_W-1:0] channel_select_bits,
  output logic wake_req,
  output logic adc_irq
);

  // ************************************************************
  // cycle counts
  // ************************************************************
  localparam int CPU_CLKS = CPU_MC * CLKS_PER_MC;
  localparam int SYNC_CLKS = SYNC_MC * CLKS_PER_MC;
  localparam logic [`APM_CNT_W-1:0] CPU_LAST = `APM_CNT_W'(CPU_CLKS - 1);
  localparam logic [`APM_CNT_W-1:0] SYNC_LAST = `APM_CNT_W'(SYNC_CLKS - 1);
  localparam logic [`APM_CNT_W-1:0] RC_LAST = `APM_CNT_W'(RC_TICKS - 1);

  apm_pkg::apm_regs_type s_q;
  apm_pkg::apm_regs_type s_d;
  logic [`APM_RES_W-1:0] code_s;
  logic rc_s;
  logic rc_tick;
  logic finish;
  logic abort;

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  // rc clock is sampled, not used as a clock: it must stay below clk/2
  apm_sync #(
    .W(`APM_RES_W + 1)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({rc_osc_pin, analog_code}),
    .dout({rc_s, code_s})
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.rc_prev = rc_s;
    rc_tick = rc_s & ~s_q.rc_prev;
    finish = 1'b0;
    // cpu-clocked conversion cannot survive a stopped cpu clock
    abort = power_down & ~s_q.rc_mode & s_q.busy;
    unique case (s_q.state)
      apm_pkg::APM_IDLE: begin
        // done must be cleared first; busy blocks restarts
        if (sw.start_wr && !s_q.busy && !s_q.done) begin
          s_d.busy = 1'b1;
          s_d.cnt = `APM_RST_CNT;
          s_d.rc_mode = converter_rc_clock_select;
          s_d.state = converter_rc_clock_select ? apm_pkg::APM_SYNC : apm_pkg::APM_CPU_RUN;
        end
      end
      apm_pkg::APM_SYNC: begin
        // hand-over from cpu clock to rc clock
        if (s_q.cnt == SYNC_LAST) begin
          s_d.cnt = `APM_RST_CNT;
          s_d.state = apm_pkg::APM_RC_RUN;
        end else begin
          s_d.cnt = s_q.cnt + `APM_CNT_W'(1);
        end
      end
      apm_pkg::APM_CPU_RUN: begin
        if (s_q.cnt == CPU_LAST) begin
          finish = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + `APM_CNT_W'(1);
        end
      end
      apm_pkg::APM_RC_RUN: begin
        // keeps counting rc ticks whatever power_down says
        if (rc_tick) begin
          if (s_q.cnt == RC_LAST) begin
            finish = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + `APM_CNT_W'(1);
          end
        end
      end
    endcase
    if (abort) begin
      s_d.state = apm_pkg::APM_IDLE;
      s_d.busy = 1'b0;
      s_d.valid = 1'b0;
      s_d.cnt = `APM_RST_CNT;
    end else if (finish) begin
      s_d.state = apm_pkg::APM_IDLE;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.result = code_s;
      s_d.valid = 1'b1;
      s_d.wake = adc_int_en & (idle_mode | power_down);
    end
    // set wins over a clear in the same cycle
    if (sw.done_clr && !(finish && !abort)) begin
      s_d.done = 1'b0;
    end
    // channel frozen while started or done
    if (sw.chan_wr && !s_q.busy && !s_q.done) begin
      s_d.chan = sw.chan_wdata;
    end
    s_d.irq = s_d.done & adc_int_en;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: apm_pkg::APM_IDLE, cnt: `APM_RST_CNT, chan: `APM_RST_CHAN,
               result: `APM_RST_RESULT, default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state register
  assign conversion_start_flag = s_q.busy;
  assign conversion_done_flag = s_q.done;
  assign conversion_result_reg = s_q.result;
  assign result_valid = s_q.valid;
  assign channel_select_bits = s_q.chan;
  assign wake_req = s_q.wake;
  assign adc_irq = s_q.irq;

  // ************************************************************
  // checks
  // ************************************************************
  // helper counters read only by the assertions
  logic [8:0] busy_len_q;
  logic [7:0] tick_len_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_q <= 9'h000;
      tick_len_q <= 8'h00;
    end else begin
      busy_len_q <= s_q.busy ? busy_len_q + 9'h001 : 9'h000;
      tick_len_q <= !s_q.busy ? 8'h00 :
                    (rc_tick && s_q.state == apm_pkg::APM_RC_RUN) ? tick_len_q + 8'h01 : tick_len_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence abort_seq;
    s_q.busy && power_down && !s_q.rc_mode;
  endsequence

  sequence done_rise_seq;
    $rose(s_q.done);
  endsequence

  cpu_conv_len_a: assert property (done_rise_seq and !s_q.rc_mode |-> busy_len_q == 9'(CPU_CLKS))
    else $error("cpu conversion length wrong");
  rc_tick_len_a: assert property (done_rise_seq and s_q.rc_mode |-> tick_len_q == 8'(RC_TICKS))
    else $error("rc conversion tick count wrong");
  rc_sync_len_a: assert property ($rose(s_q.busy) && s_q.rc_mode |-> (s_q.state == apm_pkg::APM_SYNC) [*8])
    else $error("rc synchronisation too short");
  abort_pd_a: assert property (abort_seq |=> !s_q.busy && !s_q.valid && !$rose(s_q.done))
    else $error("power down did not abort conversion");
  abort_wake_a: assert property (abort_seq |=> !s_q.wake)
    else $error("aborted conversion woke cpu");
  rc_keep_a: assert property (s_q.busy && s_q.rc_mode && power_down && !finish |=> s_q.busy)
    else $error("rc conversion stopped in power down");
  idle_wake_a: assert property (done_rise_seq and $past(adc_int_en) && $past(idle_mode) |-> s_q.wake)
    else $error("completion did not wake from idle");
  done_sticky_a: assert property (s_q.done && !sw.done_clr |=> s_q.done)
    else $error("done flag dropped without clear");
  chan_lock_a: assert property (sw.chan_wr && (s_q.busy || s_q.done) |=> $stable(s_q.chan))
    else $error("channel changed while locked");
  start_block_a: assert property (s_q.busy && sw.start_wr && !finish && !abort |=> s_q.busy && $stable(s_q.rc_mode))
    else $error("start during busy disturbed conversion");
  result_hold_a: assert property (s_q.done && !$rose(s_q.done) |-> $stable(s_q.result))
    else $error("result changed while done");

  // start that the sequencer must take
  sequence take_seq;
    sw.start_wr && !s_q.busy && !s_q.done;
  endsequence

  // clear with no completion in the same cycle
  sequence clear_seq;
    sw.done_clr && !finish;
  endsequence

  // done blocks a restart just as busy does, so a stale result is never lost
  start_take_a: assert property (take_seq |=> s_q.busy)
    else $error("accepted start did not raise busy");
  start_done_a: assert property (sw.start_wr && s_q.done |=> !s_q.busy)
    else $error("start accepted while done");
  set_wins_a: assert property (sw.done_clr && finish && !abort |=> s_q.done)
    else $error("clear beat completion");
  done_clr_a: assert property (clear_seq |=> !s_q.done)
    else $error("done flag not cleared");
  valid_done_a: assert property (done_rise_seq |-> s_q.valid && $past(s_q.busy))
    else $error("completion without valid result");
  result_cap_a: assert property (done_rise_seq |-> s_q.result == $past(code_s))
    else $error("result not taken at completion");
  chan_take_a: assert property (sw.chan_wr && !s_q.busy && !s_q.done |=> s_q.chan == $past(sw.chan_wdata))
    else $error("channel write lost");
  wake_pulse_a: assert property (s_q.wake |=> !s_q.wake)
    else $error("wake longer than one cycle");

endmodule : apm_adc_ctrl

//--- inc/apm_defines.svh
// Purpose: constants of the converter sequencing and power-mode control
// Assumes: one machine cycle is six cpu clocks
// Notes: included by the package, the controller and the bench
//
// How it works
// - with cpu clock and interrupt on, completion ends idle and wakes cpu.
// - power down with rc select 0 aborts conversion, no wake, result invalid.
// - with rc select 1, conversion continues on rc clock during power down.
// - finishing a started conversion sets the done flag for polling.
// - cpu-clocked conversion lasts exactly 31 machine cycles.
// - rc conversion takes 3-4 machine cycles plus 108-112 rc clocks.
// - start requests while busy are ignored.
// - channel bits take writes only while start and done flags are 0.
`ifndef APM_DEFINES_SVH
`define APM_DEFINES_SVH

// ************************************************************
// timing
// ************************************************************
`define APM_CLKS_PER_MC 6
`define APM_CPU_MC 31
`define APM_SYNC_MC 3
`define APM_RC_TICKS 108
`define APM_CNT_W 8

// ************************************************************
// reset values and widths
// ************************************************************
`define APM_RES_W 8
`define APM_CHAN_W 2
`define APM_RST_RESULT 8'h00
`define APM_RST_CHAN 2'h0
`define APM_RST_CNT 8'h00

`endif

//--- inc/apm_pkg.sv
// Purpose: types of the converter sequencing and power-mode control
// Assumes: apm_defines.svh gives the widths
// Notes: nothing here but the state encoding holds a number of its own
`include "apm_defines.svh"

package apm_pkg;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    APM_IDLE = 2'b00,
    APM_SYNC = 2'b01,
    APM_CPU_RUN = 2'b10,
    APM_RC_RUN = 2'b11
  } apm_state_type;

  // all sequencer state of the controller
  typedef struct packed {
    apm_state_type state;
    logic [`APM_CNT_W-1:0] cnt;
    logic rc_mode;
    logic rc_prev;
    logic busy;
    logic done;
    logic valid;
    logic wake;
    logic irq;
    logic [`APM_CHAN_W-1:0] chan;
    logic [`APM_RES_W-1:0] result;
  } apm_regs_type;

  // software strobes toward the controller
  typedef struct packed {
    logic start_wr;
    logic done_clr;
    logic chan_wr;
    logic [`APM_CHAN_W-1:0] chan_wdata;
  } apm_sw_type;

endpackage : apm_pkg

//--- core/apm_sync.sv
// Purpose: two-flop synchroniser for pin-side inputs
// Assumes: inputs are slow compared with clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps

module apm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [2*W-1:0] stage_q;
  logic [2*W-1:0] stage_d;

  // shift: low half is the first stage
  always_comb begin
    stage_d = {stage_q[W-1:0], din};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign dout = stage_q[2*W-1:W];

endmodule : apm_sync

//--- tb/test_adc_sequencing_power_modes.sv
// Purpose: self-checking bench of the converter start, done, channel and power-mode control
// Assumes: rc oscillator toggles every 75 ns, below clk/2 as the synchroniser needs
// Notes: random codes and modes from a fixed-seed xorshift
`timescale 1ns/1ps
`include "apm_defines.svh"

module test_adc_sequencing_power_modes;
  logic clk, rst_n, rc_sel, idle_mode, power_down, int_en, rc_osc, rc_on;
  apm_pkg::apm_sw_type sw;
  logic [7:0] code, result;
  logic [1:0] chan;
  logic start_flag, done_flag, valid, wake, irq;
  int mismatches, checked, wake_cnt, n;
  logic [31:0] seed = 32'h0ea3;

  apm_adc_ctrl apm_adc_ctrl_i (.clk(clk), .rst_n(rst_n), .sw(sw), .converter_rc_clock_select(rc_sel),
    .idle_mode(idle_mode), .power_down(power_down), .adc_int_en(int_en), .rc_osc_pin(rc_osc),
    .analog_code(code), .conversion_start_flag(start_flag), .conversion_done_flag(done_flag),
    .conversion_result_reg(result), .result_valid(valid), .channel_select_bits(chan),
    .wake_req(wake), .adc_irq(irq));

  // ************************************************************
  // clocks and monitors
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // rc pin running while rc_on is 1, period three clk cycles, edges always 7 ns after a clk edge
  initial begin
    rc_osc = 1'b0;
    #7; // keeps rc edges off the clk edges
    forever #75 rc_osc = rc_on & ~rc_osc;
  end
  // wake is a single-cycle pulse, so count it where it stands
  always @(posedge clk) if (wake === 1'b1) wake_cnt++;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // cpu-clocked length in clk cycles
  function automatic int cpu_len();
    return `APM_CLKS_PER_MC * `APM_CPU_MC;
  endfunction : cpu_len

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // bounded wait for the done flag
  task automatic wait_done(input int bound);
    n = 0;
    while (done_flag !== 1'b1 && n < bound) begin
      step();
      n++;
    end
    if (n >= bound) begin
      check("done_timeout", 8'h00, 8'h01);
      close_out();
    end
  endtask : wait_done

  // channel write then start; software side of the sequence
  task automatic begin_conv(input logic [1:0] ch, input logic rc);
    step(); // let any strobe just lowered pass an edge first
    seed = xs(seed);
    code = seed[15:8];
    rc_sel = rc;
    sw.chan_wr = 1'b1;
    sw.chan_wdata = ch;
    step();
    sw.chan_wr = 1'b0;
    check("chan", {6'h00, chan}, {6'h00, ch});
    sw.start_wr = 1'b1;
    step();
    sw.start_wr = 1'b0;
    check("busy", {7'h00, start_flag}, 8'h01);
  endtask : begin_conv

  // read, clear done and channel as software does
  task automatic finish_conv();
    sw.done_clr = 1'b1;
    sw.chan_wr = 1'b1;
    sw.chan_wdata = 2'h0;
    step();
    sw.done_clr = 1'b0;
    step();
    sw.chan_wr = 1'b0;
    check("done_clr", {7'h00, done_flag}, 8'h00);
    check("irq_clr", {7'h00, irq}, 8'h00);
    check("chan_clr", {6'h00, chan}, 8'h00);
  endtask : finish_conv

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sw = '0;
    rst_n = 1'b0;
    {rc_sel, idle_mode, power_down, int_en, rc_on} = 5'h00;
    code = 8'h00;
    repeat (16) step();
    check("rst_out", {start_flag, done_flag, valid, wake, irq, 1'b0, chan}, 8'h00);
    check("rst_res", result, `APM_RST_RESULT);
    rst_n = 1'b1;
    step();
    // cpu clock, every channel, random idle and interrupt enable
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      idle_mode = (i == 0) | seed[0];
      int_en = (i == 0) | seed[1];
      wake_cnt = 0;
      begin_conv(i[1:0], 1'b0);
      // retries while busy must change nothing
      step();
      sw.start_wr = 1'b1;
      sw.chan_wr = 1'b1;
      sw.chan_wdata = ~i[1:0];
      step();
      {sw.start_wr, sw.chan_wr} = 2'b00;
      check("chan_busy", {6'h00, chan}, i[7:0]);
      repeat (cpu_len() - 3) step();
      check("done_early", {7'h00, done_flag}, 8'h00);
      // a clear in the completion cycle loses to the set
      sw.done_clr = (i == 1);
      step();
      sw.done_clr = 1'b0;
      check("done_on_time", {7'h00, done_flag}, 8'h01);
      check("result", result, code);
      check("valid", {7'h00, valid}, 8'h01);
      // start and channel write while done are both refused
      sw.chan_wr = 1'b1;
      sw.start_wr = 1'b1;
      sw.chan_wdata = ~i[1:0];
      code = ~code;
      step();
      {sw.start_wr, sw.chan_wr} = 2'b00;
      step();
      check("start_done", {7'h00, start_flag}, 8'h00);
      check("chan_done", {6'h00, chan}, i[7:0]);
      check("result_hold", result, ~code);
      check("wake", wake_cnt[7:0], {7'h00, int_en & idle_mode});
      check("irq", {7'h00, irq}, {7'h00, int_en});
      finish_conv();
      $display("test cpu conversion %0d ended", i);
    end
    // power down with cpu clock aborts
    int_en = 1'b1;
    wake_cnt = 0;
    begin_conv(2'h2, 1'b0);
    seed = xs(seed);
    repeat (seed[3:0] + 2) step();
    power_down = 1'b1;
    step();
    step();
    check("abort_busy", {7'h00, start_flag}, 8'h00);
    check("abort_valid", {7'h00, valid}, 8'h00);
    repeat (cpu_len()) step();
    check("abort_done", {7'h00, done_flag}, 8'h00);
    check("abort_wake", wake_cnt[7:0], 8'h00);
    power_down = 1'b0;
    sw.chan_wr = 1'b1;
    sw.chan_wdata = 2'h0;
    step();
    sw.chan_wr = 1'b0;
    $display("test abort ended");
    // rc clock keeps converting in power down
    // rc pin switched on before the start and left running after power down ends
    rc_on = 1'b1;
    idle_mode = 1'b0;
    wake_cnt = 0;
    begin_conv(2'h3, 1'b1);
    power_down = 1'b1;
    wait_done(1000);
    checked++;
    if (n < (`APM_RC_TICKS - 1) * 3 || n > 4 * `APM_CLKS_PER_MC + 112 * 3 + 6) begin
      mismatches++;
      $display("BAD rc_length expected 108 to 112 rc clocks seen %0d cycles", n);
    end
    check("rc_result", result, code);
    step();
    check("rc_wake", wake_cnt[7:0], 8'h01);
    power_down = 1'b0;
    finish_conv();
    $display("test rc conversion ended");
    close_out();
  end
endmodule : test_adc_sequencing_power_modes
